// file: src/vsa_pkg.sv
// Constants and types for the VMEbus system-controller, slot-id and isolation block.
// Functional notes
// RULE1: Slot-id joins only first level-one acknowledge.
// RULE2: Slot-one controller drives acknowledge-out after five clocks.
// RULE3: Others wait acknowledge-in, then four clocks.
// RULE4: Last board answered by nobody; timer ends cycle.
// RULE5: Count divided by four into id, done set.
// RULE6: Slot one takes controller role, status bit set.
// RULE7: Controller drives 16 MHz backplane clock.
// RULE8: Arbiter only as controller; three modes, round-robin default.
// RULE9: Fixed mode grants highest requesting level.
// RULE10: Higher request asserts bus clear until busy negated.
// RULE11: Single level is fixed mode on level three.
// RULE12: Round-robin scans three to zero, never clears.
// RULE13: Unclaimed grant withdrawn after selected time-out.
// RULE14: Arbiter time-out counts eight microsecond ticks.
// RULE15: Acknowledge driver keeps daisy input high 30 ns.
// RULE16: Bus timer raises bus error on long strobe.
// RULE17: Isolation allows register traffic only.
// RULE18: Isolation: no acknowledge, no DMA, retries, ignores.
// RULE19: Isolation idles master, stalls DMA and interrupts.
// RULE20: Isolation floats outputs; daisy chains keep passing.
// RULE21: Four causes enter isolation.
// RULE22: Isolation bit clears only when source inactive.
// RULE23: Grant-three input sampled low makes controller.
// RULE24: Slot counter counts backplane clock edges, wide enough.
package vsa_pkg;
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned CLK_NS          = 5;
   localparam int unsigned TICK_US         = 8;
   localparam logic [10:0] TICK_CYC        = 11'(TICK_US * CLK_MHZ);
   localparam int unsigned SYSCLK_MHZ      = 16;
   localparam logic [7:0]  SCLK_STEP       = 8'(2 * SYSCLK_MHZ);
   localparam logic [7:0]  SCLK_MOD        = 8'(CLK_MHZ);
   localparam int unsigned IACK_HIGH_NS    = 30;
   localparam logic [2:0]  IACK_HIGH_CYC   = 3'((IACK_HIGH_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned ARB_TO_SHORT_US = 16;
   localparam int unsigned ARB_TO_LONG_US  = 256;
   localparam int unsigned BTO_MIN_US      = 16;
   localparam logic [7:0]  ARB_TO_SHORT_TK = 8'(ARB_TO_SHORT_US / TICK_US);
   localparam logic [7:0]  ARB_TO_LONG_TK  = 8'(ARB_TO_LONG_US / TICK_US);
   localparam logic [7:0]  BTO_MIN_TK      = 8'(BTO_MIN_US / TICK_US);
   localparam logic [2:0]  SYSCON_GAP      = 3'h5;
   localparam logic [2:0]  SLOT_GAP        = 3'h4;
   localparam logic [2:0]  IACK_LEVEL_ONE  = 3'h1;
   localparam logic [1:0]  STRAP_DELAY     = 2'h2;
   // Register byte offsets and fields.
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_STAT        = 8'h04;
   localparam logic [1:0]  ATO_SHORT       = 2'h0;
   localparam logic [1:0]  ATO_LONG        = 2'h1;
   localparam logic [2:0]  BTO_OFF         = 3'h7;
   localparam logic [2:0]  BTO_RESET       = 3'h2;
   localparam logic        ARB_RR_RESET    = 1'b1;
   // Backplane and strap inputs, all asynchronous to clk_i.
   typedef struct packed {
      logic       bg3in_n;
      logic [3:0] bgin_n;
      logic [3:0] br_n;
      logic       bbsy_n;
      logic [1:0] ds_n;
      logic       iack_n;
      logic       iackin_n;
      logic [2:0] iack_lvl;
      logic       irq1_n;
      logic       pci_rst_n;
      logic       autoid_strap;
      logic       iso_strap;
   } vsa_pins_t;
   typedef enum logic [1:0] {ARB_IDLE = 2'h0, ARB_GRANT = 2'h1, ARB_BUSY = 2'h3} vsa_arb_t;
   typedef enum logic [1:0] {AI_WAIT = 2'h0, AI_COUNT = 2'h1, AI_OUT = 2'h3, AI_DONE = 2'h2} vsa_aid_t;
endpackage : vsa_pkg

// file: src/vsa_syscon.sv
// VMEbus system controller: slot id, clock, arbiter, daisy driver, bus timer, isolation.
`timescale 1ns/1ps
`default_nettype none
module vsa_syscon (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [31:0]       dat_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              we_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   output logic [31:0]            dat_o,
   output logic                   ack_o,
   input  wire vsa_pkg::vsa_pins_t pins_i,
   output logic                   sysclk_o,
   output logic [3:0]             local_grant_out_n_o,
   output logic                   local_bus_clear_out_n_o,
   output logic                   local_bus_error_out_n_o,
   output logic                   iackout_n_o,
   output logic                   vme_drive_en_o,
   output logic                   isolate_o
);
   vsa_pkg::vsa_pins_t meta_q;
   vsa_pkg::vsa_pins_t pin_q;
   vsa_pkg::vsa_arb_t  arb_q;
   vsa_pkg::vsa_aid_t  aid_q;
   logic        syscon_q;
   logic        arb_rr_q;
   logic [1:0]  ato_sel_q;
   logic [2:0]  bto_sel_q;
   logic        irq_iso_en_q;
   logic        iso_q;
   logic        autoid_en_q;
   logic        pwr_iso_q;
   logic [1:0]  strap_cnt_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic [7:0]  slot_id_q;
   logic        slot_done_q;
   logic [7:0]  sclk_acc_q;
   logic        sclk_q;
   logic [10:0] tick_cnt_q;
   logic        tick_q;
   logic [9:0]  slot_cnt_q;
   logic [2:0]  gap_q;
   logic        armed_q;
   logic [2:0]  hold_q;
   logic        iackout_n_q;
   logic [1:0]  owner_q;
   logic [1:0]  ptr_q;
   logic [3:0]  grant_n_q;
   logic        bclr_n_q;
   logic [7:0]  ato_cnt_q;
   logic [7:0]  bto_cnt_q;
   logic        berr_n_q;
   logic        capture;
   logic        aid_start;
   logic        bus_req;
   logic        wr_ctrl;
   logic        irq_src;
   logic        sclk_rise;
   logic [8:0]  sclk_sum;
   logic [3:0]  req;
   logic [1:0]  pick;
   logic        pick_ok;
   logic [7:0]  ato_lim;
   logic [7:0]  bto_lim;
   logic [31:0] ctrl_word;
   logic        daisy_low;

   // Two-flop synchroniser for every pin; only pin_q is read by logic.
   always_ff @(posedge clk_i) begin
      meta_q <= pins_i;
      pin_q  <= meta_q;
   end

   assign req      = ~pin_q.br_n;
   assign irq_src  = ~pin_q.irq1_n & irq_iso_en_q;
   assign bus_req  = cyc_i & stb_i & ~ack_q;
   assign wr_ctrl  = cyc_i & stb_i & ack_q & we_i & (adr_i == vsa_pkg::REG_CTRL);
   assign capture  = (strap_cnt_q == vsa_pkg::STRAP_DELAY);
   assign aid_start = autoid_en_q & (aid_q == vsa_pkg::AI_WAIT) & ~pin_q.iack_n
                      & (pin_q.iack_lvl == vsa_pkg::IACK_LEVEL_ONE);
   assign sclk_sum = {1'b0, sclk_acc_q} + {1'b0, vsa_pkg::SCLK_STEP};
   assign sclk_rise = (sclk_sum >= {1'b0, vsa_pkg::SCLK_MOD}) & ~sclk_q;
   assign ctrl_word = {23'h0, iso_q, irq_iso_en_q, bto_sel_q, ato_sel_q, arb_rr_q, syscon_q};

   // Straps are caught a fixed number of cycles after reset release, once the synchroniser holds them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_cnt_q <= 2'h0;
         autoid_en_q <= 1'b0;
         pwr_iso_q   <= 1'b0;
      end else begin
         if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         if (capture) begin
            autoid_en_q <= pin_q.autoid_strap;
            pwr_iso_q   <= pin_q.iso_strap;
         end
      end
   end

   // Control register; the controller bit is loaded from the slot detector and may be overwritten.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         syscon_q     <= 1'b0;
         arb_rr_q     <= vsa_pkg::ARB_RR_RESET;
         ato_sel_q    <= vsa_pkg::ATO_SHORT;
         bto_sel_q    <= vsa_pkg::BTO_RESET;
         irq_iso_en_q <= 1'b0;
      end else if (wr_ctrl && sel_i[0]) begin
         syscon_q     <= dat_i[0];
         arb_rr_q     <= dat_i[1];
         ato_sel_q    <= dat_i[3:2];
         bto_sel_q    <= dat_i[6:4];
         irq_iso_en_q <= dat_i[7];
      end else if (capture) begin
         syscon_q <= ~pin_q.bg3in_n; // RULE23 RULE6
      end
   end

   // Isolation flag: every entry cause wins over a software clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iso_q <= 1'b0;
      end else if ((capture && pin_q.iso_strap) || (!pin_q.pci_rst_n && pwr_iso_q) || irq_src) begin
         iso_q <= 1'b1; // RULE21
      end else if (wr_ctrl && sel_i[1]) begin
         iso_q <= dat_i[8]; // RULE22
      end
   end

   // Wishbone slave: one wait state; a write lands at the edge where the master sees ack.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         if (!bus_req) begin
            dat_q <= 32'h0000_0000;
         end else if (adr_i == vsa_pkg::REG_CTRL) begin
            dat_q <= ctrl_word;
         end else if (adr_i == vsa_pkg::REG_STAT) begin
            dat_q <= {21'h0, syscon_q, iso_q, slot_done_q, slot_id_q};
         end else begin
            dat_q <= 32'h0000_0000;
         end
      end
   end

   // Fractional divider: 200 MHz is not a multiple of 32 MHz, so edges jitter by one cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_acc_q <= 8'h00;
         sclk_q     <= 1'b0;
      end else if (sclk_sum >= {1'b0, vsa_pkg::SCLK_MOD}) begin
         sclk_acc_q <= 8'(sclk_sum - {1'b0, vsa_pkg::SCLK_MOD});
         sclk_q     <= ~sclk_q; // RULE7
      end else begin
         sclk_acc_q <= sclk_sum[7:0];
      end
   end

   // Eight microsecond tick shared by the arbiter and bus timers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_q <= 11'h000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == vsa_pkg::TICK_CYC - 11'h001) begin
         tick_cnt_q <= 11'h000;
         tick_q     <= 1'b1; // RULE14
      end else begin
         tick_cnt_q <= tick_cnt_q + 11'h001;
         tick_q     <= 1'b0;
      end
   end

   // Slot identification over the first level-one acknowledge cycle after reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aid_q       <= vsa_pkg::AI_WAIT;
         slot_cnt_q  <= 10'h000;
         gap_q       <= 3'h0;
         armed_q     <= 1'b0;
         slot_id_q   <= 8'h00;
         slot_done_q <= 1'b0;
      end else begin
         case (aid_q)
            vsa_pkg::AI_WAIT: begin
               if (aid_start) begin
                  aid_q      <= vsa_pkg::AI_COUNT; // RULE1
                  slot_cnt_q <= 10'h000;
                  armed_q    <= syscon_q;
                  gap_q      <= vsa_pkg::SYSCON_GAP; // RULE2
               end
            end
            vsa_pkg::AI_COUNT: begin
               if (!armed_q && !pin_q.iackin_n) begin
                  armed_q <= 1'b1;
                  gap_q   <= vsa_pkg::SLOT_GAP; // RULE3
               end
               if (armed_q && gap_q == 3'h0) begin
                  aid_q       <= vsa_pkg::AI_OUT;
                  slot_id_q   <= slot_cnt_q[9:2]; // RULE5
                  slot_done_q <= 1'b1;
               end else if (sclk_rise) begin
                  slot_cnt_q <= slot_cnt_q + 10'h001; // RULE24
                  if (armed_q) begin
                     gap_q <= gap_q - 3'h1;
                  end
               end
               if (pin_q.iack_n) begin
                  aid_q <= vsa_pkg::AI_DONE;
               end
            end
            vsa_pkg::AI_OUT: begin
               // Nobody answers; the bus timer ends the cycle and acknowledge goes away.
               if (pin_q.iack_n) begin
                  aid_q <= vsa_pkg::AI_DONE; // RULE4
               end
            end
            default: begin
               aid_q <= vsa_pkg::AI_DONE;
            end
         endcase
      end
   end

   // Acknowledge daisy chain: the controller follows the bus acknowledge, others pass their input.
   assign daisy_low = syscon_q ? ~pin_q.iack_n : ~pin_q.iackin_n;

   // Output is held high a minimum time between cycles; chain keeps running while isolated.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iackout_n_q <= 1'b1;
         hold_q      <= 3'h0;
      end else if (aid_q == vsa_pkg::AI_COUNT || aid_start) begin
         iackout_n_q <= 1'b1; // RULE1
      end else if (aid_q == vsa_pkg::AI_OUT) begin
         iackout_n_q <= 1'b0;
      end else if (daisy_low && hold_q == 3'h0) begin
         iackout_n_q <= 1'b0; // RULE20
      end else if (!daisy_low && !iackout_n_q) begin
         iackout_n_q <= 1'b1;
         hold_q      <= vsa_pkg::IACK_HIGH_CYC; // RULE15
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end
   end

   // Level chooser: round-robin scans down from the pointer, fixed mode from level three.
   always_comb begin
      logic [1:0] lvl;
      pick    = 2'h0;
      pick_ok = 1'b0;
      lvl     = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         lvl = arb_rr_q ? 2'(ptr_q + 2'(i) + 2'h1) : 2'(i); // RULE12 RULE9
         if (req[lvl] && !pick_ok) begin
            pick    = lvl;
            pick_ok = 1'b1;
         end
      end
   end

   // Arbiter time-out limit in ticks; the first tick may come early.
   always_comb begin
      if (ato_sel_q == vsa_pkg::ATO_SHORT) begin
         ato_lim = vsa_pkg::ARB_TO_SHORT_TK; // RULE13
      end else if (ato_sel_q == vsa_pkg::ATO_LONG) begin
         ato_lim = vsa_pkg::ARB_TO_LONG_TK;
      end else begin
         ato_lim = 8'h00;
      end
   end

   // Arbiter; single-level use is fixed mode with requesters on level three only.
   always_ff @(posedge clk_i) begin
      if (rst_i || !syscon_q) begin
         arb_q     <= vsa_pkg::ARB_IDLE; // RULE8
         grant_n_q <= 4'hF;
         bclr_n_q  <= 1'b1;
         owner_q   <= 2'h0;
         ptr_q     <= 2'h3;
         ato_cnt_q <= 8'h00;
      end else begin
         case (arb_q)
            vsa_pkg::ARB_IDLE: begin
               bclr_n_q <= 1'b1;
               if (pick_ok && pin_q.bbsy_n) begin
                  arb_q            <= vsa_pkg::ARB_GRANT;
                  grant_n_q[pick]  <= 1'b0; // RULE11
                  owner_q          <= pick;
                  ptr_q            <= pick - 2'h1;
                  ato_cnt_q        <= 8'h00;
               end
            end
            vsa_pkg::ARB_GRANT: begin
               if (!pin_q.bbsy_n) begin
                  arb_q     <= vsa_pkg::ARB_BUSY;
                  grant_n_q <= 4'hF;
               end else if (ato_lim != 8'h00 && tick_q && ato_cnt_q == ato_lim - 8'h01) begin
                  arb_q     <= vsa_pkg::ARB_IDLE; // RULE13
                  grant_n_q <= 4'hF;
               end else if (tick_q) begin
                  ato_cnt_q <= ato_cnt_q + 8'h01;
               end
            end
            vsa_pkg::ARB_BUSY: begin
               if (pin_q.bbsy_n) begin
                  arb_q    <= vsa_pkg::ARB_IDLE;
                  bclr_n_q <= 1'b1; // RULE10
               end else if (!arb_rr_q && (req >> owner_q) > 4'h1) begin
                  bclr_n_q <= 1'b0; // RULE10
               end
            end
            default: begin
               arb_q <= vsa_pkg::ARB_IDLE;
            end
         endcase
      end
   end

   // Bus timer limit: 16 us doubled per step, top code disables it.
   assign bto_lim = (bto_sel_q == vsa_pkg::BTO_OFF) ? 8'h00 : 8'(vsa_pkg::BTO_MIN_TK << bto_sel_q);

   // Bus timer: error is held until both strobes are released.
   always_ff @(posedge clk_i) begin
      if (rst_i || !syscon_q || pin_q.ds_n == 2'h3) begin
         bto_cnt_q <= 8'h00;
         berr_n_q  <= 1'b1;
      end else if (bto_lim != 8'h00 && tick_q && bto_cnt_q == bto_lim - 8'h01) begin
         berr_n_q <= 1'b0; // RULE16 RULE4
      end else if (tick_q && berr_n_q) begin
         bto_cnt_q <= bto_cnt_q + 8'h01;
      end
   end

   // Registered outputs; isolation floats backplane drivers but grant chain still passes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sysclk_o                <= 1'b0;
         local_grant_out_n_o     <= 4'hF;
         local_bus_clear_out_n_o <= 1'b1;
         local_bus_error_out_n_o <= 1'b1;
         vme_drive_en_o          <= 1'b0;
         isolate_o               <= 1'b0;
      end else begin
         sysclk_o                <= sclk_q & syscon_q;
         local_grant_out_n_o     <= syscon_q ? grant_n_q : pin_q.bgin_n; // RULE20
         local_bus_clear_out_n_o <= bclr_n_q;
         local_bus_error_out_n_o <= berr_n_q;
         vme_drive_en_o          <= ~iso_q; // RULE20
         isolate_o               <= iso_q; // RULE17 RULE18 RULE19
      end
   end

   assign iackout_n_o = iackout_n_q;
   assign ack_o       = ack_q;
   assign dat_o       = dat_q;
endmodule : vsa_syscon
`default_nettype wire

// file: test/vsa_checker.sv
// Port-level checker for the system-controller block.
`timescale 1ns/1ps
`default_nettype none
module vsa_checker (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic [7:0]         adr_i,
   input wire logic [31:0]        dat_i,
   input wire logic [3:0]         sel_i,
   input wire logic               we_i,
   input wire logic               cyc_i,
   input wire logic               stb_i,
   input wire logic               ack_o,
   input wire vsa_pkg::vsa_pins_t pins_i,
   input wire logic               sysclk_o,
   input wire logic [3:0]         local_grant_out_n_o,
   input wire logic               local_bus_clear_out_n_o,
   input wire logic               local_bus_error_out_n_o,
   input wire logic               iackout_n_o,
   input wire logic               vme_drive_en_o,
   input wire logic               isolate_o
);
   logic [2:0]  ctl_q;
   logic [11:0] gnt_q;
   logic [13:0] ds_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Mirror of round-robin mode, short grant time-out and interrupt isolation enable, from completed writes.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ctl_q <= 3'h3;
      else if (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00 && sel_i[0])
         ctl_q <= {dat_i[7], dat_i[3:2] == 2'h0, dat_i[1]};
   end
   // Cycles a grant stands unclaimed, and cycles a data strobe stays low.
   always_ff @(posedge clk_i) begin
      gnt_q <= (&local_grant_out_n_o || !pins_i.bbsy_n) ? 12'h000 : gnt_q + 12'h001;
      ds_q  <= (pins_i.ds_n == 2'h3) ? 14'h0000 : ds_q + 14'h0001;
   end
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered after one cycle");
   one_grant_a: assert property ($countones(~local_grant_out_n_o) <= 1)
      else $error("more than one grant at a time");
   rr_no_clear_a: assert property (ctl_q[0] |-> local_bus_clear_out_n_o)
      else $error("bus clear in round-robin mode");
   clear_hold_a: assert property (!local_bus_clear_out_n_o && !pins_i.bbsy_n |=> !local_bus_clear_out_n_o)
      else $error("bus clear dropped while busy");
   clear_drop_a: assert property ($rose(pins_i.bbsy_n) |-> ##[1:5] local_bus_clear_out_n_o)
      else $error("bus clear stuck after busy released");
   grant_late_a: assert property (ctl_q[1] |-> gnt_q <= 12'hCE4)
      else $error("unclaimed grant outlived its time-out");
   grant_early_a: assert property ($rose(&local_grant_out_n_o) && pins_i.bbsy_n && $past(pins_i.bbsy_n, 4)
         |-> gnt_q >= 12'h636)
      else $error("unclaimed grant withdrawn too soon");
   berr_gap_a: assert property ($fell(local_bus_error_out_n_o) |-> ds_q >= 14'h0636)
      else $error("bus error before the shortest period");
   berr_end_a: assert property ((pins_i.ds_n == 2'h3) [*5] |-> local_bus_error_out_n_o)
      else $error("bus error held with strobes released");
   iso_float_a: assert property (isolate_o |-> !vme_drive_en_o)
      else $error("drivers enabled while isolated");
   iso_irq_a: assert property (ctl_q[2] && !pins_i.irq1_n |-> ##[1:5] isolate_o)
      else $error("enabled interrupt input did not isolate");
   iack_rest_a: assert property ($rose(iackout_n_o) |-> iackout_n_o [*6])
      else $error("daisy output high for under 30 ns");
   sysclk_half_a: assert property ($rose(sysclk_o) |-> sysclk_o [*6])
      else $error("system clock high phase too short");
   cover property (!local_bus_clear_out_n_o);
   cover property (!iackout_n_o);
   cover property (!local_bus_error_out_n_o);
endmodule : vsa_checker
`default_nettype wire

// file: test/vsa_board_model.sv
// Model of the other backplane boards that request and hold the bus.
`timescale 1ns/1ps
`default_nettype none
module vsa_board_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [3:0] req_i,
   input  wire logic       claim_i,
   input  wire logic [3:0] grant_n_i,
   output logic [3:0]      br_n_o,
   output logic            bbsy_n_o
);
   logic [3:0] own_q;
   // A requester drops its request once it owns the bus, and stays busy until it lets go.
   assign br_n_o   = ~(req_i & ~own_q);
   assign bbsy_n_o = ~|own_q;
   // With claim low a granted board never answers, which exercises the grant time-out.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         own_q <= 4'h0;
      else if (!(|own_q) && claim_i)
         own_q <= ~grant_n_i & req_i;
      else
         own_q <= own_q & req_i;
   end
endmodule : vsa_board_model
`default_nettype wire

// file: test/vsa_syscon_bench.sv
// Self-checking testbench for the system-controller block.
`timescale 1ns/1ps
`default_nettype none
module vsa_syscon_bench;
   localparam int TICK = int'(vsa_pkg::TICK_CYC);
   logic               clk_i   = 1'b0;
   logic               rst_i   = 1'b1;
   logic [7:0]         adr_i   = 8'h00;
   logic [31:0]        dat_i   = 32'h0;
   logic [3:0]         sel_i   = 4'hF;
   logic               we_i    = 1'b0;
   logic               cyc_i   = 1'b0;
   logic               stb_i   = 1'b0;
   logic [3:0]         req_q   = 4'h0;
   logic               claim_q = 1'b0;
   logic [31:0]        dat_o, rd_q;
   logic               ack_o, sysclk_o, clr_n, berr_n, iackout_n, drive_en, isolate, bbsy_n;
   logic [3:0]         grant_n, br_n;
   vsa_pkg::vsa_pins_t pin_q, pins_i;
   int                 err_count = 0;
   int                 checks = 0;
   int                 cycles = 0;
   // Clock, and the pin bundle built from bench levels and the board model.
   always #2.5 clk_i = ~clk_i;
   always_comb begin
      pins_i        = pin_q;
      pins_i.br_n   = br_n;
      pins_i.bbsy_n = bbsy_n;
   end
   vsa_syscon i_vsa_syscon (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o,
      .pins_i, .sysclk_o, .local_grant_out_n_o(grant_n), .local_bus_clear_out_n_o(clr_n),
      .local_bus_error_out_n_o(berr_n), .iackout_n_o(iackout_n), .vme_drive_en_o(drive_en), .isolate_o(isolate));
   vsa_board_model i_vsa_board_model (.clk_i, .rst_i, .req_i(req_q), .claim_i(claim_q), .grant_n_i(grant_n),
      .br_n_o(br_n), .bbsy_n_o(bbsy_n));
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // A slow handshake would otherwise hang the run, so a ceiling ends it.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk
   // One classic cycle: held until ack is sampled, released at that same edge.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd_q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic gwait(input logic [3:0] exp);
      for (int i = 0; i < 200 && grant_n !== exp; i++) @(posedge clk_i);
      chk("grant", 32'(exp), 32'(grant_n));
   endtask : gwait
   task automatic t_regs();
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl reset", 32'h0000_0023, rd_q);
      wb(1'b1, 8'h04, 32'hFFFF_FFFF);
      wb(1'b0, 8'h04, 32'h0);
      chk("status reset", 32'h0000_0400, rd_q);
      wb(1'b0, 8'h08, 32'h0);
      chk("unmapped read", 32'h0, rd_q);
   endtask : t_regs
   task automatic t_clock();
      int   n = 0;
      logic p = sysclk_o;
      repeat (1000) begin
         @(posedge clk_i);
         n += int'(sysclk_o && !p);
         p = sysclk_o;
      end
      chk("sysclk rises", 32'h1, 32'(n >= 79 && n <= 81));
   endtask : t_clock
   task automatic t_slot_id();
      int   n = 0;
      logic p = sysclk_o;
      @(posedge clk_i);
      pin_q.iack_lvl <= vsa_pkg::IACK_LEVEL_ONE;
      pin_q.iack_n   <= 1'b0;
      pin_q.ds_n     <= 2'h0;
      while (iackout_n !== 1'b0) begin
         @(posedge clk_i);
         n += int'(sysclk_o && !p);
         p = sysclk_o;
      end
      chk("rises to ack-out", 32'h1, 32'(n == 5 || n == 6));
      n = 0;
      while (berr_n !== 1'b0) begin
         @(posedge clk_i);
         n++;
      end
      chk("stall length", 32'h1, 32'(n > 7 * TICK - 200 && n < 8 * TICK + 20));
      pin_q.iack_n <= 1'b1;
      pin_q.ds_n   <= 2'h3;
      repeat (8) @(posedge clk_i);
      chk("bus error end", 32'h1, 32'(berr_n));
      wb(1'b0, 8'h04, 32'h0);
      chk("slot id", 32'h0000_0501, rd_q);
   endtask : t_slot_id
   task automatic t_arbiter();
      int n = 0;
      @(posedge clk_i);
      claim_q <= 1'b1;
      req_q   <= 4'h5;
      gwait(4'hB);
      req_q <= 4'h9;
      gwait(4'hE);
      req_q <= 4'h8;
      gwait(4'h7);
      req_q <= 4'h0;
      wb(1'b1, 8'h00, 32'h0000_0021);
      req_q <= 4'h6;
      gwait(4'hB);
      req_q <= 4'hE;
      for (int i = 0; i < 20 && clr_n; i++) @(posedge clk_i);
      chk("bus clear", 32'h0, 32'(clr_n));
      req_q <= 4'hA;
      gwait(4'h7);
      chk("bus clear off", 32'h1, 32'(clr_n));
      req_q   <= 4'h0;
      claim_q <= 1'b0;
      gwait(4'hF);
      req_q <= 4'h2;
      gwait(4'hD);
      while (grant_n !== 4'hF) begin
         @(posedge clk_i);
         n++;
      end
      req_q <= 4'h0;
      chk("grant time-out", 32'h1, 32'(n >= TICK && n <= 2 * TICK + 20));
      // A regrant to the dropped request may still stand unclaimed; let it expire too.
      repeat (2 * TICK) @(posedge clk_i);
      gwait(4'hF);
   endtask : t_arbiter
   task automatic t_isolate();
      wb(1'b1, 8'h00, 32'h0000_0121);
      repeat (4) @(posedge clk_i);
      chk("isolate by write", 32'h1, 32'(isolate));
      chk("drivers off", 32'h0, 32'(drive_en));
      claim_q <= 1'b1;
      req_q   <= 4'h8;
      gwait(4'h7);
      req_q <= 4'h0;
      wb(1'b1, 8'h00, 32'h0000_00A1);
      repeat (4) @(posedge clk_i);
      chk("isolate cleared", 32'h0, 32'(isolate));
      pin_q.irq1_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("isolate by irq", 32'h1, 32'(isolate));
      wb(1'b0, 8'h00, 32'h0);
      chk("isolation flag", 32'h0000_01A1, rd_q);
      wb(1'b1, 8'h00, 32'h0000_00A1);
      repeat (4) @(posedge clk_i);
      chk("clear refused", 32'h1, 32'(isolate));
      pin_q.irq1_n <= 1'b1;
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h00, 32'h0000_00A1);
      repeat (4) @(posedge clk_i);
      chk("clear accepted", 32'h0, 32'(isolate));
   endtask : t_isolate
   // Slot-one board with the slot-id option; reset held 20 cycles.
   initial begin
      pin_q              = '0;
      pin_q.bgin_n       = 4'hF;
      pin_q.ds_n         = 2'h3;
      pin_q.iack_n       = 1'b1;
      pin_q.iackin_n     = 1'b1;
      pin_q.irq1_n       = 1'b1;
      pin_q.pci_rst_n    = 1'b1;
      pin_q.autoid_strap = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      t_regs();
      t_clock();
      t_slot_id();
      t_arbiter();
      t_isolate();
      tally_and_finish();
   end
endmodule : vsa_syscon_bench
bind vsa_syscon vsa_checker i_vsa_checker (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i,
   .ack_o, .pins_i, .sysclk_o, .local_grant_out_n_o, .local_bus_clear_out_n_o, .local_bus_error_out_n_o,
   .iackout_n_o, .vme_drive_en_o, .isolate_o);
`default_nettype wire
